// File: core/slow_clock_timers.sv
// Watchdog, periodic slow timer and clock calibration with APB slave
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/100ps
module slow_clock_timers (
	input wire logic pclk,
	input wire logic presetn,
	input wire slow_timers_pkg::apb_req_t apb_req,
	output slow_timers_pkg::apb_rsp_t apb_rsp,
	input wire logic internal_slow_clk,
	input wire logic external_slow_clk,
	input wire logic standby_or_sleep,
	input wire logic debug_mode,
	input wire logic rtc_irq_enable,
	output logic chip_reset,
	output logic reset_source_watchdog,
	output logic rtc_irq,
	output logic watchdog_enable,
	output logic internal_slow_osc_enable,
	output logic external_slow_osc_enable,
	output logic external_slow_analog_form,
	output logic low_voltage_warn_enable,
	output logic low_voltage_warn_irq_enable
);
	localparam logic [2:0] FIRE_LAST = slow_timers_pkg::WD_FIRE_TICKS - 3'h1;
	localparam logic [2:0] EDGE_LAST = slow_timers_pkg::CAL_EDGES - 3'h1;

	// One-hot register decode of a byte address
	function automatic logic [slow_timers_pkg::NUM_REGS-1:0] reg_hit(
		input logic [slow_timers_pkg::ADDR_W-1:0] a
	);
		logic [15:0] idx;
		idx = a[slow_timers_pkg::ADDR_W-1:2];
		reg_hit = '0;
		if (a[1:0] == 2'b00) begin
			reg_hit[slow_timers_pkg::SEL_CCFG] =
				(idx == slow_timers_pkg::IDX_CHIP_CONFIG_ONE);
			reg_hit[slow_timers_pkg::SEL_WDC] =
				(idx == slow_timers_pkg::IDX_WATCHDOG_CONTROL);
			reg_hit[slow_timers_pkg::SEL_WDR] =
				(idx == slow_timers_pkg::IDX_WATCHDOG_RELOAD_HIGH);
			reg_hit[slow_timers_pkg::SEL_RTCL] =
				(idx == slow_timers_pkg::IDX_RTC_COUNT_LIMIT);
			reg_hit[slow_timers_pkg::SEL_RTCS] =
				(idx == slow_timers_pkg::IDX_RTC_STATUS_CONTROL);
			reg_hit[slow_timers_pkg::SEL_CAL] =
				(idx == slow_timers_pkg::IDX_CLOCK_CALIBRATION);
		end
	endfunction

	logic [2:0] isl_q;
	logic [2:0] esl_q;
	logic int_tick;
	logic ext_tick;
	logic sel_tick;
	logic [slow_timers_pkg::NUM_REGS-1:0] hit;
	logic [slow_timers_pkg::NUM_REGS-1:0] wsel;
	logic acc;
	logic [31:0] wd;
	logic [31:0] prdata_q;
	logic lvw_en_q;
	logic lvw_ie_q;
	logic wd_en_q;
	logic wd_flag_q;
	logic [7:0] reload_q;
	logic [15:0] wd_cnt_q;
	logic [2:0] fire_cnt_q;
	slow_timers_pkg::wd_state_t wd_state_q;
	slow_timers_pkg::wd_state_t wd_state_d;
	logic wd_go;
	logic wd_step;
	logic refresh;
	logic wd_overflow;
	logic chip_reset_q;
	logic rst_src_q;
	logic [15:0] limit_q;
	logic [15:0] rtc_cnt_q;
	logic rtc_en_q;
	logic ovf_q;
	logic sck_sel_q;
	logic isosc_q;
	logic eaf_q;
	logic esosc_q;
	logic rtc_wrap;
	logic rtc_irq_q;
	slow_timers_pkg::cal_state_t cal_state_q;
	logic [11:0] cal_cnt_q;
	logic [11:0] cal_res_q;
	logic [2:0] cal_edges_q;
	logic meas_busy;
	logic cal_start;

	// Slow clock pins: two-flop sync, third flop for edge detect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			isl_q <= 3'h7; // Ones: no false rise after reset
			esl_q <= 3'h7;
		end else begin
			isl_q <= {isl_q[1:0], internal_slow_clk};
			esl_q <= {esl_q[1:0], external_slow_clk};
		end
	end

	// Rising edges of the slow clocks as one-cycle enables
	assign int_tick = isl_q[1] & ~isl_q[2];
	assign ext_tick = esl_q[1] & ~esl_q[2];
	assign sel_tick = sck_sel_q ? ext_tick : int_tick;

	// Bus decode; writes land in the access phase
	assign hit = reg_hit(apb_req.paddr);
	assign acc = apb_req.psel & apb_req.penable;
	assign wsel = hit & {slow_timers_pkg::NUM_REGS{acc & apb_req.pwrite}};
	assign wd = apb_req.pwdata;
	assign apb_rsp.prdata = prdata_q;
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = acc & ~(|hit);

	// Read data captured in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= slow_timers_pkg::RD_ZERO;
		end else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
			prdata_q <= slow_timers_pkg::RD_ZERO;
			case (1'b1)
				hit[slow_timers_pkg::SEL_CCFG]: begin
					prdata_q[slow_timers_pkg::CCFG_LVW_EN_BIT] <= lvw_en_q;
					prdata_q[slow_timers_pkg::CCFG_LVW_IE_BIT] <= lvw_ie_q;
					prdata_q[slow_timers_pkg::CCFG_WD_EN_BIT] <= wd_en_q;
				end
				hit[slow_timers_pkg::SEL_WDC]: begin
					prdata_q[slow_timers_pkg::WDC_FLAG_BIT] <= wd_flag_q;
				end
				hit[slow_timers_pkg::SEL_WDR]: begin
					prdata_q[7:0] <= reload_q;
				end
				hit[slow_timers_pkg::SEL_RTCL]: begin
					prdata_q[15:0] <= rtc_cnt_q;
				end
				hit[slow_timers_pkg::SEL_RTCS]: begin
					prdata_q[slow_timers_pkg::RTC_EN_BIT] <= rtc_en_q;
					prdata_q[slow_timers_pkg::RTC_OVF_BIT] <= ovf_q;
					prdata_q[slow_timers_pkg::RTC_SEL_BIT] <= sck_sel_q;
					prdata_q[slow_timers_pkg::RTC_ISOSC_BIT] <= isosc_q;
					prdata_q[slow_timers_pkg::RTC_EAF_BIT] <= eaf_q;
					prdata_q[slow_timers_pkg::RTC_ESOSC_BIT] <= esosc_q;
				end
				hit[slow_timers_pkg::SEL_CAL]: begin
					prdata_q[slow_timers_pkg::CAL_START_BIT] <= meas_busy;
					prdata_q[slow_timers_pkg::CAL_RES_W-1:0] <= cal_res_q;
				end
				default: begin
					prdata_q <= slow_timers_pkg::RD_ZERO;
				end
			endcase
		end
	end

	// Chip configuration bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvw_en_q <= 1'b0;
			lvw_ie_q <= 1'b0;
			wd_en_q <= 1'b0;
		end else if (wsel[slow_timers_pkg::SEL_CCFG]) begin
			lvw_en_q <= wd[slow_timers_pkg::CCFG_LVW_EN_BIT];
			lvw_ie_q <= wd[slow_timers_pkg::CCFG_LVW_IE_BIT];
			wd_en_q <= wd[slow_timers_pkg::CCFG_WD_EN_BIT];
		end
	end

	// Watchdog reload high byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reload_q <= slow_timers_pkg::WD_RELOAD_RST;
		end else if (wsel[slow_timers_pkg::SEL_WDR]) begin
			reload_q <= wd[7:0];
		end
	end

	// Watchdog controls; debug forces it off, sleep freezes it
	assign wd_go = wd_en_q & ~debug_mode;
	assign wd_step = int_tick & ~standby_or_sleep;
	assign refresh = wsel[slow_timers_pkg::SEL_WDC] &
		wd[slow_timers_pkg::WDC_REFRESH_BIT];
	assign wd_overflow = (wd_state_q == slow_timers_pkg::WD_RUN) && wd_go &&
		wd_step && !refresh && (wd_cnt_q == slow_timers_pkg::WD_MAX);

	// Watchdog state decision
	always_comb begin
		wd_state_d = wd_state_q;
		case (wd_state_q)
			slow_timers_pkg::WD_OFF: begin
				if (wd_go) begin
					wd_state_d = slow_timers_pkg::WD_RUN;
				end
			end
			slow_timers_pkg::WD_RUN: begin
				if (!wd_go) begin
					wd_state_d = slow_timers_pkg::WD_OFF;
				end else if (wd_overflow) begin
					wd_state_d = slow_timers_pkg::WD_FIRE;
				end
			end
			slow_timers_pkg::WD_FIRE: begin
				if (int_tick && fire_cnt_q == FIRE_LAST) begin
					wd_state_d = wd_go ? slow_timers_pkg::WD_RUN :
						slow_timers_pkg::WD_OFF;
				end
			end
			default: begin
				wd_state_d = slow_timers_pkg::WD_OFF;
			end
		endcase
	end

	// Watchdog state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_state_q <= slow_timers_pkg::WD_OFF;
		end else begin
			wd_state_q <= wd_state_d;
		end
	end

	// Watchdog counter: zero when off, reload on refresh
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_cnt_q <= 16'h0000;
		end else if (wd_state_q != slow_timers_pkg::WD_RUN) begin
			wd_cnt_q <= 16'h0000;
		end else if (refresh) begin
			wd_cnt_q <= {reload_q, slow_timers_pkg::WD_LOW_LOAD};
		end else if (wd_step) begin
			wd_cnt_q <= wd_cnt_q + 16'h0001;
		end
	end

	// Reset pulse length in internal slow ticks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fire_cnt_q <= 3'h0;
			chip_reset_q <= 1'b0;
			rst_src_q <= 1'b0;
		end else begin
			chip_reset_q <= (wd_state_d == slow_timers_pkg::WD_FIRE);
			rst_src_q <= wd_overflow;
			if (wd_state_q != slow_timers_pkg::WD_FIRE) begin
				fire_cnt_q <= 3'h0;
			end else if (int_tick && fire_cnt_q != FIRE_LAST) begin
				fire_cnt_q <= fire_cnt_q + 3'h1;
			end
		end
	end

	// Watchdog reset flag: set wins over a software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_flag_q <= 1'b0;
		end else if (wd_overflow) begin
			wd_flag_q <= 1'b1;
		end else if (wsel[slow_timers_pkg::SEL_WDC] &&
			!wd[slow_timers_pkg::WDC_FLAG_BIT]) begin
			wd_flag_q <= 1'b0;
		end
	end

	// Periodic timer status and control bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rtc_en_q <= 1'b0;
			sck_sel_q <= 1'b0;
			isosc_q <= 1'b0;
			eaf_q <= 1'b0;
			esosc_q <= 1'b0;
		end else if (wsel[slow_timers_pkg::SEL_RTCS]) begin
			rtc_en_q <= wd[slow_timers_pkg::RTC_EN_BIT];
			sck_sel_q <= wd[slow_timers_pkg::RTC_SEL_BIT];
			isosc_q <= wd[slow_timers_pkg::RTC_ISOSC_BIT];
			eaf_q <= wd[slow_timers_pkg::RTC_EAF_BIT];
			esosc_q <= wd[slow_timers_pkg::RTC_ESOSC_BIT];
		end
	end

	// Limit register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			limit_q <= slow_timers_pkg::RTC_LIMIT_RST;
		end else if (wsel[slow_timers_pkg::SEL_RTCL]) begin
			limit_q <= wd[15:0];
		end
	end

	assign rtc_wrap = rtc_en_q & sel_tick & (rtc_cnt_q == limit_q);

	// Live counter; a new limit restarts it from zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rtc_cnt_q <= 16'h0000;
		end else if (wsel[slow_timers_pkg::SEL_RTCL] || rtc_wrap) begin
			rtc_cnt_q <= 16'h0000;
		end else if (rtc_en_q && sel_tick) begin
			rtc_cnt_q <= rtc_cnt_q + 16'h0001;
		end
	end

	// Overflow flag: set wins, cleared only by writing zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_q <= 1'b0;
		end else if (rtc_wrap) begin
			ovf_q <= 1'b1;
		end else if (wsel[slow_timers_pkg::SEL_RTCS] &&
			!wd[slow_timers_pkg::RTC_OVF_BIT]) begin
			ovf_q <= 1'b0;
		end
	end

	// Interrupt event pulse, gated by the enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rtc_irq_q <= 1'b0;
		end else begin
			rtc_irq_q <= rtc_wrap & rtc_irq_enable;
		end
	end

	// Calibration: arm on a slow edge, then count four periods
	assign meas_busy = (cal_state_q != slow_timers_pkg::CAL_IDLE);
	assign cal_start = wsel[slow_timers_pkg::SEL_CAL] &
		wd[slow_timers_pkg::CAL_START_BIT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cal_state_q <= slow_timers_pkg::CAL_ARM;
			cal_cnt_q <= 12'h000;
			cal_edges_q <= 3'h0;
			cal_res_q <= slow_timers_pkg::CAL_NONE;
		end else begin
			case (cal_state_q)
				slow_timers_pkg::CAL_IDLE: begin
					if (cal_start) begin
						cal_state_q <= slow_timers_pkg::CAL_ARM;
						cal_cnt_q <= 12'h000;
						cal_edges_q <= 3'h0;
					end else if (wsel[slow_timers_pkg::SEL_CAL]) begin
						cal_res_q <= wd[slow_timers_pkg::CAL_RES_W-1:0];
					end
				end
				slow_timers_pkg::CAL_ARM: begin
					if (sel_tick) begin
						cal_state_q <= slow_timers_pkg::CAL_COUNT;
						cal_cnt_q <= 12'h000;
					end else if (cal_cnt_q == slow_timers_pkg::CAL_MAX) begin
						cal_state_q <= slow_timers_pkg::CAL_IDLE;
						cal_res_q <= slow_timers_pkg::CAL_NONE;
					end else begin
						cal_cnt_q <= cal_cnt_q + 12'h001;
					end
				end
				slow_timers_pkg::CAL_COUNT: begin
					if (cal_cnt_q == slow_timers_pkg::CAL_MAX) begin
						cal_state_q <= slow_timers_pkg::CAL_IDLE;
						cal_res_q <= slow_timers_pkg::CAL_MAX;
					end else if (sel_tick && cal_edges_q == EDGE_LAST) begin
						cal_state_q <= slow_timers_pkg::CAL_IDLE;
						cal_res_q <= cal_cnt_q + 12'h001;
					end else begin
						cal_cnt_q <= cal_cnt_q + 12'h001;
						if (sel_tick) begin
							cal_edges_q <= cal_edges_q + 3'h1;
						end
					end
				end
				default: begin
					cal_state_q <= slow_timers_pkg::CAL_IDLE;
				end
			endcase
		end
	end

	// Outputs
	assign chip_reset = chip_reset_q;
	assign reset_source_watchdog = rst_src_q;
	assign rtc_irq = rtc_irq_q;
	assign watchdog_enable = wd_en_q;
	assign internal_slow_osc_enable = isosc_q;
	assign external_slow_osc_enable = esosc_q;
	assign external_slow_analog_form = eaf_q;
	assign low_voltage_warn_enable = lvw_en_q;
	assign low_voltage_warn_irq_enable = lvw_ie_q;

	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence wd_enter_run;
		wd_state_q == slow_timers_pkg::WD_OFF && wd_go;
	endsequence
	sequence wd_last_fire_tick;
		wd_state_q == slow_timers_pkg::WD_FIRE && int_tick &&
			fire_cnt_q == FIRE_LAST;
	endsequence

	wdt_start_zero_a: assert property (wd_enter_run |=> wd_cnt_q == 16'h0000 ##1 wd_cnt_q <= 16'h0001) else $error("watchdog did not start at zero");
	wdt_fire_entry_a: assert property (wd_overflow |=> chip_reset && reset_source_watchdog) else $error("overflow gave no reset");
	wdt_fire_end_a: assert property (wd_last_fire_tick |=> !chip_reset && $past(chip_reset)) else $error("reset pulse length wrong");
	wdt_fire_ticks_a: assert property (fire_cnt_q <= FIRE_LAST) else $error("reset pulse overran");
	wdt_sleep_hold_a: assert property (wd_state_q == slow_timers_pkg::WD_RUN && standby_or_sleep && !refresh |=> $stable(wd_cnt_q)) else $error("watchdog counted in sleep");
	wdt_debug_off_a: assert property (debug_mode && wd_state_q != slow_timers_pkg::WD_FIRE |=> wd_state_q != slow_timers_pkg::WD_RUN) else $error("watchdog ran in debug");
	wdt_flag_set_a: assert property ($rose(chip_reset) |-> wd_flag_q) else $error("reset flag not set");
	wdt_refresh_load_a: assert property (refresh && wd_state_q == slow_timers_pkg::WD_RUN && wd_go |=> wd_cnt_q == {reload_q, 8'h00}) else $error("refresh load wrong");
	rtc_wrap_a: assert property (rtc_wrap && !wsel[slow_timers_pkg::SEL_RTCL] |=> rtc_cnt_q == 16'h0000 && ovf_q) else $error("timer wrap wrong");
	rtc_flag_keep_a: assert property (ovf_q && !wsel[slow_timers_pkg::SEL_RTCS] |=> ovf_q) else $error("overflow flag lost");
	rtc_irq_gate_a: assert property (rtc_irq |-> $past(rtc_wrap) && $past(rtc_irq_enable)) else $error("stray timer interrupt");
	meas_start_a: assert property (cal_start && !meas_busy |=> meas_busy) else $error("calibration did not start");
endmodule

// File: core/slow_timers_pkg.sv
// Constants, register map and carrier types for the slow-clock timers
// Contract
// - Enabled watchdog starts at zero, counts slow ticks
// - All-ones count fires four-tick chip reset
// - Standby or sleep freezes the watchdog count
// - Debug mode forces the watchdog inactive
// - Watchdog reset sets the reset-source flag
// - Writing refresh one reloads; zero does nothing
// - Reload register gives counter upper eight bits
// - Watchdog enable lives at config bit five
// - Timer runs while bit seven set; write sets limit
// - Reading the count register returns live count
// - Count to limit, clear, restart, request interrupt
// - Overflow flag bit six cleared only by software
// - Interrupt enable gates the overflow interrupt event
// - Select bit picks slow source for timer, calibration
// - Twelve-bit fast counter measures four slow cycles
// - Bit fifteen write starts; reads busy while measuring
// - Result lands in bits eleven to zero
// - Zero means no slow clock; all-ones means overflow
package slow_timers_pkg;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;
	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_CHIP_CONFIG_ONE = 16'h401e;
	localparam logic [15:0] IDX_WATCHDOG_CONTROL = 16'h4026;
	localparam logic [15:0] IDX_WATCHDOG_RELOAD_HIGH = 16'h4027;
	localparam logic [15:0] IDX_RTC_COUNT_LIMIT = 16'h402c;
	localparam logic [15:0] IDX_RTC_STATUS_CONTROL = 16'h402e;
	localparam logic [15:0] IDX_CLOCK_CALIBRATION = 16'h4044;
	// Decode slots
	localparam int NUM_REGS = 6;
	localparam int SEL_CCFG = 0;
	localparam int SEL_WDC = 1;
	localparam int SEL_WDR = 2;
	localparam int SEL_RTCL = 3;
	localparam int SEL_RTCS = 4;
	localparam int SEL_CAL = 5;
	// Field positions
	localparam int CCFG_LVW_EN_BIT = 7;
	localparam int CCFG_LVW_IE_BIT = 6;
	localparam int CCFG_WD_EN_BIT = 5;
	localparam int WDC_FLAG_BIT = 1;
	localparam int WDC_REFRESH_BIT = 0;
	localparam int RTC_EN_BIT = 7;
	localparam int RTC_OVF_BIT = 6;
	localparam int RTC_SEL_BIT = 5;
	localparam int RTC_ISOSC_BIT = 4;
	localparam int RTC_EAF_BIT = 3;
	localparam int RTC_ESOSC_BIT = 2;
	localparam int CAL_START_BIT = 15;
	localparam int CAL_RES_W = 12;
	// Reset values and limits
	localparam logic [15:0] RTC_LIMIT_RST = 16'hffff;
	localparam logic [15:0] WD_MAX = 16'hffff;
	localparam logic [7:0] WD_RELOAD_RST = 8'h00;
	localparam logic [7:0] WD_LOW_LOAD = 8'h00;
	localparam logic [2:0] WD_FIRE_TICKS = 3'h4;
	localparam logic [2:0] CAL_EDGES = 3'h4;
	localparam logic [11:0] CAL_MAX = 12'hfff;
	localparam logic [11:0] CAL_NONE = 12'h000;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
	// State encodings
	typedef enum logic [2:0] {
		WD_OFF = 3'b001,
		WD_RUN = 3'b010,
		WD_FIRE = 3'b100
	} wd_state_t;
	typedef enum logic [2:0] {
		CAL_IDLE = 3'b001,
		CAL_ARM = 3'b010,
		CAL_COUNT = 3'b100
	} cal_state_t;
	// APB carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [DATA_W-1:0] pwdata;
	} apb_req_t;
	typedef struct packed {
		logic [DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;
endpackage

// File: tb/slow_clock_timers_tb.sv
// Self-checking bench for the slow-clock timers block
`timescale 1ns/100ps
module slow_clock_timers_tb;
	localparam logic [15:0] CCFG = slow_timers_pkg::IDX_CHIP_CONFIG_ONE;
	localparam logic [15:0] WDC = slow_timers_pkg::IDX_WATCHDOG_CONTROL;
	localparam logic [15:0] WDR = slow_timers_pkg::IDX_WATCHDOG_RELOAD_HIGH;
	localparam logic [15:0] LIM = slow_timers_pkg::IDX_RTC_COUNT_LIMIT;
	localparam logic [15:0] STS = slow_timers_pkg::IDX_RTC_STATUS_CONTROL;
	localparam logic [15:0] CAL = slow_timers_pkg::IDX_CLOCK_CALIBRATION;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	slow_timers_pkg::apb_req_t apb_req = '0;
	slow_timers_pkg::apb_rsp_t apb_rsp;
	logic internal_slow_clk = 1'b0;
	logic external_slow_clk = 1'b0;
	logic standby_or_sleep = 1'b0;
	logic debug_mode = 1'b0;
	logic rtc_irq_enable = 1'b0;
	logic chip_reset, reset_source_watchdog, rtc_irq, watchdog_enable;
	logic internal_slow_osc_enable, external_slow_osc_enable;
	logic external_slow_analog_form, low_voltage_warn_enable;
	logic low_voltage_warn_irq_enable;
	int fail_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int t0 = 0;
	int ext_half = 120;
	bit ext_run = 1'b0;
	logic [31:0] rd = '0;
	logic [31:0] v0 = '0;
	logic err = 1'b0;
	logic [15:0] rst_idx [5] = '{CCFG, WDC, WDR, LIM, STS};

	// Bus clock and the two slow pins, each a whole multiple of the pclk period
	always #10 pclk = ~pclk;
	always #80 internal_slow_clk = ~internal_slow_clk;
	always #(ext_half) if (ext_run) external_slow_clk = ~external_slow_clk;

	slow_clock_timers dut (
		.pclk(pclk),
		.presetn(presetn),
		.apb_req(apb_req),
		.apb_rsp(apb_rsp),
		.internal_slow_clk(internal_slow_clk),
		.external_slow_clk(external_slow_clk),
		.standby_or_sleep(standby_or_sleep),
		.debug_mode(debug_mode),
		.rtc_irq_enable(rtc_irq_enable),
		.chip_reset(chip_reset),
		.reset_source_watchdog(reset_source_watchdog),
		.rtc_irq(rtc_irq),
		.watchdog_enable(watchdog_enable),
		.internal_slow_osc_enable(internal_slow_osc_enable),
		.external_slow_osc_enable(external_slow_osc_enable),
		.external_slow_analog_form(external_slow_analog_form),
		.low_voltage_warn_enable(low_voltage_warn_enable),
		.low_voltage_warn_irq_enable(low_voltage_warn_irq_enable)
	);

	// Verdict and end of run
	task automatic stop_test();
		if (fail_count == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Exact and ranged comparisons
	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string m);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic check_rng(input logic [31:0] got, input int lo,
		input int hi, input string m);
		checks_done++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			fail_count++;
			$display("ERROR %0t %s got %0d", $time, m, got);
		end
	endtask

	// One APB transfer; holds the request until pready at an edge
	task automatic apb(input logic wr, input logic [15:0] idx,
		input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		apb_req.psel <= 1'b1;
		apb_req.penable <= 1'b0;
		apb_req.pwrite <= wr;
		apb_req.paddr <= {idx, 2'b00};
		apb_req.pwdata <= wd;
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (apb_rsp.pready !== 1'b1 && n < 50);
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		check_rng(n, 1, 49, "bus answer");
	endtask

	// Waits for chip_reset or rtc_irq to reach a level; t0 -1 if never
	task automatic wait_for(input bit pick, input logic lvl, input int lim);
		logic s;
		t0 = 0;
		do begin
			@(posedge pclk);
			t0++;
			s = pick ? rtc_irq : chip_reset;
		end while (s !== lvl && t0 < lim);
		if (s !== lvl) t0 = -1;
	endtask

	// Polls the calibration register until it is idle
	task automatic wait_cal();
		int k;
		k = 0;
		do begin
			apb(1'b0, CAL, 32'h0000_0000);
			k++;
		end while (rd[15] !== 1'b0 && k < 2000);
	endtask

	// Reset values, unmapped access, calibration from power-up
	task automatic t_basic();
		apb(1'b0, CAL, 32'h0000_0000);
		check(rd[15], 1'b1, "busy after reset");
		foreach (rst_idx[i]) begin
			apb(1'b0, rst_idx[i], 32'h0000_0000);
			check(rd, 32'h0000_0000, "reset value");
		end
		apb(1'b0, 16'h4030, 32'h0000_0000);
		check(err, 1'b1, "unmapped error");
		check(rd, 32'h0000_0000, "unmapped read");
		apb(1'b1, CCFG, 32'h0000_00c0);
		@(posedge pclk);
		check({low_voltage_warn_enable, low_voltage_warn_irq_enable}, 2'b11,
			"warn outs");
		apb(1'b0, CCFG, 32'h0000_0000);
		check(rd, 32'h0000_00c0, "config read back");
		apb(1'b1, CCFG, 32'h0000_0000);
		wait_cal();
		check_rng(rd[11:0], 31, 33, "internal cal");
	endtask

	// Calibration on the external source, absent and too slow
	task automatic t_cal();
		ext_run = 1'b1;
		apb(1'b1, STS, 32'h0000_002c);
		apb(1'b1, CAL, 32'h0000_8000);
		apb(1'b0, CAL, 32'h0000_0000);
		check(rd[15], 1'b1, "busy while measuring");
		wait_cal();
		check_rng(rd[11:0], 47, 49, "external cal");
		ext_run = 1'b0;
		apb(1'b1, CAL, 32'h0000_8000);
		wait_cal();
		check(rd[11:0], 12'h000, "no slow clock");
		ext_half = 11000;
		ext_run = 1'b1;
		apb(1'b1, CAL, 32'h0000_8000);
		wait_cal();
		check(rd[11:0], 12'hfff, "count overflow");
		ext_run = 1'b0;
		apb(1'b1, STS, 32'h0000_0000);
	endtask

	// Periodic timer: period, flag, gating, live count, source select
	task automatic t_rtc();
		rtc_irq_enable <= 1'b1;
		apb(1'b1, LIM, 32'h0000_0003);
		apb(1'b1, STS, 32'h0000_0090);
		@(posedge pclk);
		check(internal_slow_osc_enable, 1'b1, "osc enable out");
		wait_for(1'b1, 1'b1, 100);
		wait_for(1'b1, 1'b1, 100);
		check(t0, 32, "irq period");
		repeat (5) @(posedge pclk);
		apb(1'b0, STS, 32'h0000_0000);
		check(rd[7:6], 2'b11, "flag stays set");
		apb(1'b1, STS, 32'h0000_0010);
		apb(1'b0, STS, 32'h0000_0000);
		check(rd, 32'h0000_0010, "flag cleared");
		rtc_irq_enable <= 1'b0;
		apb(1'b1, STS, 32'h0000_0090);
		wait_for(1'b1, 1'b1, 100);
		check(t0, -1, "irq masked");
		apb(1'b0, STS, 32'h0000_0000);
		check(rd[6], 1'b1, "flag without irq");
		apb(1'b1, LIM, 32'h0000_0fff);
		apb(1'b0, LIM, 32'h0000_0000);
		v0 = rd;
		repeat (80) @(posedge pclk);
		apb(1'b0, LIM, 32'h0000_0000);
		check_rng(rd - v0, 9, 12, "live count");
		ext_run = 1'b1;
		rtc_irq_enable <= 1'b1;
		apb(1'b1, LIM, 32'h0000_0003);
		apb(1'b1, STS, 32'h0000_00ac);
		@(posedge pclk);
		check({external_slow_osc_enable, external_slow_analog_form}, 2'b11,
			"external outs");
		wait_for(1'b1, 1'b1, 100);
		wait_for(1'b1, 1'b1, 100);
		check(t0, 48, "external period");
		apb(1'b1, STS, 32'h0000_0000);
	endtask

	// Watchdog: reload, overflow pulse, flag, standby, debug
	task automatic t_wd();
		apb(1'b1, WDR, 32'h0000_00ff);
		apb(1'b1, CCFG, 32'h0000_0020);
		@(posedge pclk);
		check(watchdog_enable, 1'b1, "wd enable bit");
		apb(1'b1, WDC, 32'h0000_0001);
		repeat (500) @(posedge pclk);
		apb(1'b1, WDC, 32'h0000_0000);
		wait_for(1'b0, 1'b1, 2600);
		check_rng(t0 + 503, 2010, 2090, "reload time");
		check(reset_source_watchdog, 1'b1, "source pulse");
		wait_for(1'b0, 1'b0, 100);
		check_rng(t0, 24, 36, "reset width");
		apb(1'b0, WDC, 32'h0000_0000);
		check(rd, 32'h0000_0002, "reset flag");
		apb(1'b1, WDC, 32'h0000_0001);
		standby_or_sleep <= 1'b1;
		repeat (1000) @(posedge pclk);
		standby_or_sleep <= 1'b0;
		wait_for(1'b0, 1'b1, 3000);
		check_rng(t0, 2010, 2090, "standby hold");
		wait_for(1'b0, 1'b0, 100);
		apb(1'b1, WDC, 32'h0000_0001);
		debug_mode <= 1'b1;
		wait_for(1'b0, 1'b1, 2400);
		check(t0, -1, "debug stops wd");
		debug_mode <= 1'b0;
		apb(1'b1, CCFG, 32'h0000_0000);
		@(posedge pclk);
		check(watchdog_enable, 1'b0, "wd disable bit");
	endtask

	// Hang guard
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fail_count++;
			$display("ERROR %0t run timed out", $time);
			stop_test();
		end
	end

	// Main sequence
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_basic();
		t_rtc();
		t_cal();
		t_wd();
		stop_test();
	end
endmodule
